// file: core/sar_adc_parallel_control.sv
// Purpose: Control logic of a 16-bit SAR converter with parallel port
// Assumes: Host pins synchronous to i_mclk; comparator is an input
// Notes:   Conversion timing comes from the internal step counter
//
// Behaviour
// - Conversion starts on start falling edge while chip select is low
// - Start and read are ignored while chip select is high
// - Starts are ignored until the acquisition after the running conversion ends
// - Approximation register loads 8000h (MSB trial bit) at the start of each conversion
// - Sixteen bits resolved one per step, MSB first
// - Finished word is copied into the output holding latch
// - Busy low during conversion, high otherwise
// - New result is on the bus by the busy rising edge
// - Data driven only while read and chip select are both low
// - Result is two's complement, bit 15 is the MSB; the code gives straight binary (8000h midscale, FFFFh top)
// - Conversion takes typically 3.3 us, at most 3.8 us; here 32 cycles of 100 ns, 3.2 us
// - Acquisition completes within 480 ns after conversion ends
// - Acquisition plus conversion fits in 4 us for 250 ksps
// - Power-down low shuts down; chip select picks nap or sleep
// - Nap keeps logic alive; ready again 200 ns after release
// - With read tied to start, previous result shows until completion
`timescale 1ns/100ps
`default_nettype none
module sar_adc_parallel_control
    import conv_ctl_pkg::*;
(
    input  wire logic                i_mclk,
    input  wire logic                i_rst_n,
    input  wire host_ctl_s           i_host,
    input  wire logic                i_comparator,
    output logic [RESULT_W-1:0]      o_result_bus,
    output logic [RESULT_W-1:0]      o_result_bus_oe_n,
    output logic                     o_busy_n,
    output logic                     o_nap,
    output logic                     o_sleep,
    output logic                     o_acquiring
);
    ctl_state_e          state;
    ctl_state_e          next_state;
    logic [CNT_W-1:0]    step_cnt;
    logic [CNT_W-1:0]    next_step_cnt;
    logic                start_n_q;
    logic                selected;
    logic                start_edge;
    logic                start_ok;
    logic                shutdown;
    logic                step_tick;
    logic                sar_last;
    logic                conv_done;
    logic [RESULT_W-1:0] sar_value;
    logic [RESULT_W-1:0] holding_latch;
    logic                read_en;

    // =================================================================
    // Strobe decode
    assign selected   = !i_host.chip_select_n;
    assign shutdown   = !i_host.power_down_n;
    assign start_edge = start_n_q && !i_host.conversion_start_n;
    // Starts only count when idle and powered; a start during ACQ is the
    // host's fault and is dropped rather than corrupting the sample.
    assign start_ok   = start_edge && selected && !shutdown
                        && (state == ST_IDLE);
    assign step_tick  = (state == ST_CONV)
                        && (step_cnt == CNT_W'(STEP_CYC - 1));
    assign conv_done  = step_tick && sar_last;
    assign read_en    = selected && !i_host.read_n;

    // =================================================================
    // Next state
    always_comb
    begin
        next_state    = state;
        next_step_cnt = step_cnt;
        case (state)
            ST_IDLE:
            begin
                next_step_cnt = '0;
                if (start_ok)
                    next_state = ST_CONV;
            end
            ST_CONV:
            begin
                next_step_cnt = step_tick ? '0 : step_cnt + 1'b1;
                if (conv_done)
                    next_state = ST_ACQ;
            end
            ST_ACQ:
            begin
                next_step_cnt = step_cnt + 1'b1;
                if (step_cnt == CNT_W'(ACQ_CYC - 1))
                begin
                    next_state    = shutdown ? ST_WAKE : ST_IDLE;
                    next_step_cnt = '0;
                end
            end
            ST_WAKE:
            begin
                // Held here during shutdown; wake timer runs after release
                if (shutdown)
                    next_step_cnt = '0;
                else if (step_cnt == CNT_W'(WAKE_CYC - 1))
                    next_state = ST_IDLE;
                else
                    next_step_cnt = step_cnt + 1'b1;
            end
            default:
            begin
                next_state    = ST_IDLE;
                next_step_cnt = '0;
            end
        endcase
        if (shutdown && state == ST_IDLE)
        begin
            next_state    = ST_WAKE;
            next_step_cnt = '0;
        end
    end

    // =================================================================
    // State registers
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state     <= ST_IDLE;
            step_cnt  <= '0;
            start_n_q <= 1'b1;
        end
        else
        begin
            state     <= next_state;
            step_cnt  <= next_step_cnt;
            start_n_q <= i_host.conversion_start_n;
        end
    end

    sar_step u_sar (
        .i_mclk     (i_mclk),
        .i_rst_n    (i_rst_n),
        .i_clear    (start_ok),
        .i_step     (step_tick),
        .i_keep_bit (i_comparator),
        .o_value    (sar_value),
        .o_last     (sar_last)
    );

    // =================================================================
    // Output latch and pins; latch and busy change on the same edge,
    // so the word is stable when busy rises.
    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            holding_latch <= RESULT_RST;
        else if (conv_done)
            holding_latch <= {sar_value[15:1], i_comparator};
    end

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_result_bus      <= RESULT_RST;
            o_result_bus_oe_n <= 16'hFFFF;
            o_busy_n          <= 1'b1;
            o_nap             <= 1'b0;
            o_sleep           <= 1'b0;
            o_acquiring       <= 1'b0;
        end
        else
        begin
            // Old word stays until completion, also with read on start
            o_result_bus      <= conv_done
                                 ? {sar_value[15:1], i_comparator}
                                 : holding_latch;
            o_result_bus_oe_n <= {RESULT_W{!read_en}};
            o_busy_n          <= !(next_state == ST_CONV);
            o_nap             <= shutdown && selected;
            o_sleep           <= shutdown && !selected;
            o_acquiring       <= (next_state == ST_ACQ);
        end
    end
endmodule : sar_adc_parallel_control
`default_nettype wire

// file: core/conv_ctl_pkg.sv
// Purpose: Shared constants and carriers for the converter control block
// Assumes: 10 MHz core clock (100 ns period)
// Notes:   Timing counts are derived from printed times by expression
package conv_ctl_pkg;
    // =================================================================
    // Widths and clock
    localparam int RESULT_W       = 16;
    localparam int CLK_PERIOD_NS  = 100;
    // =================================================================
    // Timing (times in ns as printed, counts in clock cycles)
    localparam int CONV_TYP_NS    = 3300;
    localparam int CONV_MAX_NS    = 3800;
    localparam int ACQ_MAX_NS     = 480;
    localparam int NAP_WAKE_NS    = 200;
    // One decision per step; typical time spread over the bit steps
    localparam int CONV_CYC       = CONV_TYP_NS / CLK_PERIOD_NS;
    localparam int STEP_CYC       = CONV_CYC / RESULT_W;
    localparam int ACQ_CYC        = ACQ_MAX_NS / CLK_PERIOD_NS;
    localparam int WAKE_CYC       = NAP_WAKE_NS / CLK_PERIOD_NS;
    localparam int CNT_W          = 8;
    // =================================================================
    // Reset values
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam logic [15:0] SAR_RST    = 16'h0000;

    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_ACQ, ST_WAKE} ctl_state_e;

    typedef struct packed {
        logic chip_select_n;
        logic read_n;
        logic conversion_start_n;
        logic power_down_n;
    } host_ctl_s;

    typedef struct packed {
        logic [15:0] data;
        logic [15:0] oe_n;
    } result_bus_s;
endpackage : conv_ctl_pkg

// file: core/sar_step.sv
// Purpose: Successive-approximation register with bit pointer
// Assumes: Comparator decision is a synchronous input
// Notes:   Loads 8000h on start, resolves MSB first
`timescale 1ns/100ps
`default_nettype none
module sar_step
    import conv_ctl_pkg::*;
(
    input  wire logic                i_mclk,
    input  wire logic                i_rst_n,
    input  wire logic                i_clear,
    input  wire logic                i_step,
    input  wire logic                i_keep_bit,
    output logic [RESULT_W-1:0]      o_value,
    output logic                     o_last
);
    logic [RESULT_W-1:0] approximation_register;
    logic [RESULT_W-1:0] bit_ptr;
    logic [RESULT_W-1:0] next_value;

    // =================================================================
    // Trial bit is set, kept or dropped by the comparator
    assign next_value = i_keep_bit ? approximation_register
                                   : (approximation_register & ~bit_ptr);

    always_ff @(posedge i_mclk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            approximation_register <= SAR_RST;
            bit_ptr                <= 16'h8000;
        end
        else if (i_clear)
        begin
            approximation_register <= 16'h8000;
            bit_ptr                <= 16'h8000;
        end
        else if (i_step)
        begin
            approximation_register <= next_value | (bit_ptr >> 1);
            bit_ptr                <= bit_ptr >> 1;
        end
    end

    assign o_value = approximation_register;
    assign o_last  = bit_ptr[0];
endmodule : sar_step
`default_nettype wire

// file: testbench/conv_ctl_asserts.sv
// Purpose: Port checker for the converter control block
// Assumes: 32-cycle conversion, 4-cycle acquisition
// Notes:   Bound to the top module below
`timescale 1ns/100ps
`default_nettype none
module conv_ctl_asserts
    import conv_ctl_pkg::*;
(
    input wire logic                i_mclk,
    input wire logic                i_rst_n,
    input wire host_ctl_s           i_host,
    input wire logic                i_comparator,
    input wire logic [RESULT_W-1:0] o_result_bus,
    input wire logic [RESULT_W-1:0] o_result_bus_oe_n,
    input wire logic                o_busy_n,
    input wire logic                o_nap,
    input wire logic                o_sleep,
    input wire logic                o_acquiring
);
    // ==========
    // Helpers
    wire        sel  = !i_host.chip_select_n;
    wire        down = !i_host.power_down_n;
    wire        rd   = !i_host.read_n;
    wire        fall = !i_host.conversion_start_n;
    logic [7:0] low_cnt;
    always_ff @(posedge i_mclk or negedge i_rst_n)
        if (!i_rst_n)
            low_cnt <= 8'h00;
        else
            low_cnt <= o_busy_n ? 8'h00 : low_cnt + 8'h01;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    // Three quiet cycles rule out the wake window after power-down
    sequence s_take;
        $rose(fall) && sel && o_busy_n && !o_acquiring && !down
            && !$past(down) && !$past(down, 2) && !$past(down, 3);
    endsequence
    sequence s_acq;
        o_acquiring [*4] ##1 !o_acquiring;
    endsequence
    // ==========
    // Properties
    a_start_busy: assert property (
        s_take |=> !o_busy_n)
        else $error("start not taken");
    a_cs_ignore: assert property (
        $rose(fall) && !sel && o_busy_n |=> o_busy_n)
        else $error("start taken while deselected");
    a_busy_len: assert property (
        $rose(o_busy_n) |-> low_cnt == 8'h20)
        else $error("busy low time wrong");
    a_busy_max: assert property (
        !o_busy_n |-> low_cnt < 8'h20)
        else $error("busy low too long");
    a_acq_win: assert property (
        $rose(o_busy_n) |-> s_acq)
        else $error("acquisition window wrong");
    a_hold_res: assert property (
        $changed(o_result_bus) |-> $rose(o_busy_n))
        else $error("result changed off busy rise");
    a_oe_drive: assert property (
        sel && rd |=> o_result_bus_oe_n == 16'h0000)
        else $error("bus not driven");
    a_oe_float: assert property (
        !(sel && rd) |=> o_result_bus_oe_n == 16'hFFFF)
        else $error("bus not released");
    a_nap_mode: assert property (
        down && sel && o_busy_n && !o_acquiring |=> o_nap && !o_sleep)
        else $error("nap not entered");
    a_sleep_mode: assert property (
        down && !sel && o_busy_n && !o_acquiring |=> o_sleep && !o_nap)
        else $error("sleep not entered");
    a_down_ignore: assert property (
        (o_nap || o_sleep) && $rose(fall) |=> o_busy_n)
        else $error("start taken in shutdown");
endmodule : conv_ctl_asserts
bind sar_adc_parallel_control conv_ctl_asserts u_chk (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_host(i_host), .i_comparator(i_comparator),
    .o_result_bus(o_result_bus), .o_result_bus_oe_n(o_result_bus_oe_n),
    .o_busy_n(o_busy_n), .o_nap(o_nap), .o_sleep(o_sleep),
    .o_acquiring(o_acquiring));
`default_nettype wire

// file: testbench/conv_host_model.sv
// Purpose: Host processor model driving the control pins
// Assumes: Pins change on the falling clock edge
// Notes:   Released bus reads back inverted, no pull resistors
`timescale 1ns/100ps
`default_nettype none
module conv_host_model
    import conv_ctl_pkg::*;
(
    input  wire logic                i_mclk,
    input  wire logic [RESULT_W-1:0] i_bus,
    input  wire logic [RESULT_W-1:0] i_oe_n,
    output var  host_ctl_s           o_host,
    output var  logic                o_comparator,
    output wire logic [RESULT_W-1:0] o_wire
);
    logic [RESULT_W-1:0] last = 16'h0000;
    initial o_host = 4'hF;
    initial o_comparator = 1'b0;
    assign o_wire = (i_bus & ~i_oe_n) | (~last & i_oe_n);
    always @(posedge i_mclk) last <= o_wire;
    // ==========
    // Pin tasks
    task pins(input logic cs_n, input logic rd_n, input logic pd_n);
        @(negedge i_mclk);
        o_host.chip_select_n = cs_n;
        o_host.read_n = rd_n;
        o_host.power_down_n = pd_n;
    endtask : pins
    // One cycle low keeps the rising edge clear of bit decisions
    task pulse(input logic keep);
        @(negedge i_mclk);
        o_comparator = keep;
        o_host.conversion_start_n = 1'b0;
        @(negedge i_mclk);
        o_host.conversion_start_n = 1'b1;
    endtask : pulse
endmodule : conv_host_model
`default_nettype wire

// file: testbench/sar_adc_parallel_control_test.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Comparator decision held for a whole conversion
// Notes:   Results are all-ones or all-zeros by construction
`timescale 1ns/100ps
`default_nettype none
module sar_adc_parallel_control_test
    import conv_ctl_pkg::*;
;
    logic                i_mclk = 1'b0;
    logic                i_rst_n = 1'b0;
    host_ctl_s           host;
    logic                comp;
    logic [RESULT_W-1:0] bus;
    logic [RESULT_W-1:0] oe_n;
    logic [RESULT_W-1:0] wire_v;
    logic                busy_n;
    logic                nap;
    logic                sleep;
    logic                acq;
    int                  error_cnt = 0;
    int                  n_tests = 0;
    int                  n;
    always #50 i_mclk = ~i_mclk;
    sar_adc_parallel_control u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_host(host), .i_comparator(comp), .o_result_bus(bus),
        .o_result_bus_oe_n(oe_n), .o_busy_n(busy_n), .o_nap(nap),
        .o_sleep(sleep), .o_acquiring(acq));
    conv_host_model u_host (.i_mclk(i_mclk), .i_bus(bus), .i_oe_n(oe_n),
        .o_host(host), .o_comparator(comp), .o_wire(wire_v));
    // ==========
    // Tasks
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Counts busy-low cycles; gives up after 40 so a refusal reads 0
    task conv(input logic keep, output int cyc);
        u_host.pulse(keep);
        // Busy is already low at the negedge where the pulse returns
        cyc = busy_n ? 0 : 1;
        for (int i = 0; i < 40 && !(cyc > 0 && busy_n); i++)
        begin
            @(negedge i_mclk);
            cyc += busy_n ? 0 : 1;
        end
    endtask : conv
    task stop_test;
        $display("errors=%0d checks=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test
    initial
    begin
        #300000;
        error_cnt++;
        stop_test();
    end
    // ==========
    // Sequence
    initial
    begin
        repeat (6) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst_n = 1'b1;
        chk(oe_n, 16'hFFFF);
        chk({bus[14:0], busy_n}, 16'h0001);
        u_host.pins(1'b0, 1'b1, 1'b1);
        conv(1'b1, n);
        chk(16'(n), 16'h0020);
        chk(bus, 16'hFFFF);
        repeat (4) @(negedge i_mclk);
        conv(1'b0, n);
        chk(bus, 16'h0000);
        // Acquisition must pass before the next start is honoured
        repeat (4) @(negedge i_mclk);
        u_host.pins(1'b0, 1'b0, 1'b1);
        u_host.pulse(1'b1);
        repeat (10) @(negedge i_mclk);
        chk(wire_v, 16'h0000);
        repeat (25) @(negedge i_mclk);
        chk(wire_v, 16'hFFFF);
        repeat (4) @(negedge i_mclk);
        u_host.pulse(1'b0);
        repeat (8) @(negedge i_mclk);
        u_host.pulse(1'b0);
        repeat (24) @(negedge i_mclk);
        chk({wire_v[14:0], busy_n}, 16'h0001);
        repeat (4) @(negedge i_mclk);
        u_host.pins(1'b1, 1'b0, 1'b1);
        conv(1'b1, n);
        chk(16'(n), 16'h0000);
        chk(oe_n, 16'hFFFF);
        u_host.pins(1'b0, 1'b0, 1'b0);
        @(negedge i_mclk);
        chk({14'h0000, nap, sleep}, 16'h0002);
        conv(1'b1, n);
        chk(16'(n), 16'h0000);
        chk(wire_v, 16'h0000);
        u_host.pins(1'b0, 1'b1, 1'b1);
        repeat (2) @(negedge i_mclk);
        conv(1'b1, n);
        chk(16'(n), 16'h0020);
        repeat (4) @(negedge i_mclk);
        u_host.pins(1'b1, 1'b1, 1'b0);
        @(negedge i_mclk);
        chk({14'h0000, nap, sleep}, 16'h0001);
        u_host.pins(1'b1, 1'b1, 1'b1);
        repeat (20) @(negedge i_mclk);
        stop_test();
    end
endmodule : sar_adc_parallel_control_test
`default_nettype wire
